/* pcw_params.svh */
// Named offsets, field positions, reset values and timing counts for the I/O window sizing block
`ifndef PCW_PARAMS_SVH
`define PCW_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PCW_IDX_CTRL_A 12'h807
`define PCW_IDX_CTRL_B 12'h847
`define PCW_IDX_STATUS 12'h880
`define PCW_LOC_CTRL_A 8'h07
`define PCW_LOC_CTRL_B 8'h47
`define PCW_CTRL_RST 8'h00

// ----------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------
`define PCW_B_W0_WIDTH 0
`define PCW_B_W0_AUTO 1
`define PCW_B_W0_SHORT 2
`define PCW_B_W0_WAIT 3
`define PCW_B_W1_WIDTH 4
`define PCW_B_W1_AUTO 5

// ----------------------------------------------------------------
// Status byte fields
// ----------------------------------------------------------------
`define PCW_S_BUSY 0
`define PCW_S_WIDE 1
`define PCW_S_WIN 2
`define PCW_S_SOCK 3
`define PCW_S_AUTO 4

// ----------------------------------------------------------------
// Timing: ISA cycle time and cycle lengths in ISA cycles
// ----------------------------------------------------------------
`define PCW_MCLK_NS 40
`define PCW_ISA_NS 120
`define PCW_ISA_DIV ((`PCW_ISA_NS + `PCW_MCLK_NS - 1) / `PCW_MCLK_NS)
`define PCW_LEN_NARROW 6
`define PCW_LEN_WIDE 3
`define PCW_LEN_SHORT 3
`define PCW_LEN_EXTRA 1

`endif

/* pcw_pkg.sv */
// Types shared by the I/O window sizing block
package pcw_pkg;

    typedef enum logic [1:0] {
        PCW_IDLE = 2'b00,
        PCW_RUN = 2'b01
    } pcw_state_t;

    typedef enum logic {
        PCW_NARROW = 1'b0,
        PCW_WIDE = 1'b1
    } pcw_width_t;

endpackage

/* pcw_cycle_timer.sv */
// Down counter of ISA-equivalent cycles, paced by a divided enable
`timescale 1ns/1ps
`default_nettype none

module pcw_cycle_timer #(
    parameter int DIV = 3,
    parameter int LEN_W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Start of a timed access
    input wire logic load,
    input wire logic [LEN_W-1:0] load_len,
    // Progress
    output logic running,
    output logic expired
);
    localparam int DW = $clog2(DIV + 1);

    logic [DW-1:0] div_r;
    logic [LEN_W-1:0] left_r;
    logic run_r;
    wire logic tick;

    // Divider restarts on load so every access gets whole ISA cycles
    assign tick = run_r && (div_r == DW'(DIV - 1));
    assign expired = tick && (left_r == LEN_W'(1));
    assign running = run_r;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            div_r <= '0;
            left_r <= '0;
            run_r <= 1'h0;
        end
        else if (load)
        begin
            div_r <= '0;
            left_r <= load_len;
            run_r <= 1'h1;
        end
        else if (run_r)
        begin
            div_r <= tick ? '0 : DW'(div_r + DW'(1));
            if (tick)
                left_r <= LEN_W'(left_r - LEN_W'(1));
            if (expired)
                run_r <= 1'h0;
        end
    end

endmodule

`default_nettype wire

/* pcw_io_sizing.sv */
// APB control byte for two sockets that sizes and times PC Card I/O window accesses
`timescale 1ns/1ps
`default_nettype none
`include "pcw_params.svh"

// Function
// - Window 1 auto sizing set: width of each access comes from card IOIS16.
// - Window 1 width bit is ignored while window 1 auto sizing is set.
// - Window 1 without auto sizing: width bit 0 gives 8 bits, 1 gives 16.
// - Window 0 wait bit adds one ISA wait to 16-bit cycles only.
// - Window 0 zero-wait bit cuts 8-bit cycles to three ISA cycles only.
// - Window 0 auto sizing set: width of each access comes from card IOIS16.
// - Window 0 width bit ignored under auto sizing; else 0 is 8, 1 is 16.
// - Control byte at 0x807 (A, local 0x07) and 0x847 (B, 0x47); resets zero.
module pcw_io_sizing
    import pcw_pkg::*;
#(
    parameter int ADDR_W = 14,
    parameter int LEN_W = 4,
    parameter int DIV = `PCW_ISA_DIV
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // Card I/O access request
    input wire logic acc_req,
    input wire logic acc_win,
    input wire logic acc_sock,
    input wire logic card_iois16_n,
    // Access progress
    output logic acc_busy,
    output logic acc_wide,
    output logic acc_done
);

    // ----------------------------------------------------------------
    // Register bus decode
    // ----------------------------------------------------------------
    logic [7:0] ctrl_a_r;
    logic [7:0] ctrl_b_r;
    logic [31:0] prdata_r;
    wire logic [11:0] idx;
    wire logic aligned;
    wire logic hit_a;
    wire logic hit_b;
    wire logic hit_st;
    wire logic mapped;
    wire logic setup_ph;
    wire logic access_ph;
    wire logic wr_a;
    wire logic wr_b;
    wire logic [7:0] status;
    wire logic [31:0] rd_mux;

    assign idx = paddr[13:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign hit_a = aligned && (idx == `PCW_IDX_CTRL_A);
    assign hit_b = aligned && (idx == `PCW_IDX_CTRL_B);
    assign hit_st = aligned && (idx == `PCW_IDX_STATUS);
    assign mapped = hit_a || hit_b || hit_st;
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    // Byte lane 0 carries the control byte; other lanes are dropped
    assign wr_a = access_ph && pwrite && hit_a && pstrb[0];
    assign wr_b = access_ph && pwrite && hit_b && pstrb[0];

    // Zero wait states; the read word is captured in the setup cycle
    assign pready = 1'h1;
    assign pslverr = access_ph && !mapped;
    assign prdata = prdata_r;

    assign rd_mux = hit_a ? {24'h000000, ctrl_a_r} :
                    hit_b ? {24'h000000, ctrl_b_r} :
                    hit_st ? {24'h000000, status} : 32'h00000000;

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            ctrl_a_r <= `PCW_CTRL_RST;
            ctrl_b_r <= `PCW_CTRL_RST;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            if (wr_a)
                ctrl_a_r <= pwdata[7:0];
            if (wr_b)
                ctrl_b_r <= pwdata[7:0];
            if (setup_ph && !pwrite)
                prdata_r <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Width and length selection
    // ----------------------------------------------------------------
    wire logic [7:0] ctrl_sel;
    wire logic auto_sel;
    wire logic width_bit;
    wire pcw_width_t width_now;
    wire logic [LEN_W-1:0] len_w0;
    wire logic [LEN_W-1:0] len_w1;
    wire logic [LEN_W-1:0] len_now;

    assign ctrl_sel = acc_sock ? ctrl_b_r : ctrl_a_r;
    assign auto_sel = acc_win ? ctrl_sel[`PCW_B_W1_AUTO] : ctrl_sel[`PCW_B_W0_AUTO];
    assign width_bit = acc_win ? ctrl_sel[`PCW_B_W1_WIDTH] : ctrl_sel[`PCW_B_W0_WIDTH];
    // IOIS16 is active low: a low level asks for a 16-bit transfer
    assign width_now = pcw_width_t'(auto_sel ? !card_iois16_n : width_bit);

    assign len_w0 = (width_now == PCW_WIDE) ?
                    LEN_W'(`PCW_LEN_WIDE + (ctrl_sel[`PCW_B_W0_WAIT] ? `PCW_LEN_EXTRA : 0)) :
                    LEN_W'(ctrl_sel[`PCW_B_W0_SHORT] ? `PCW_LEN_SHORT : `PCW_LEN_NARROW);
    // Window 1 has no wait or zero-wait controls; standard lengths only
    assign len_w1 = (width_now == PCW_WIDE) ? LEN_W'(`PCW_LEN_WIDE) : LEN_W'(`PCW_LEN_NARROW);
    assign len_now = acc_win ? len_w1 : len_w0;

    // ----------------------------------------------------------------
    // Access sequencing
    // ----------------------------------------------------------------
    pcw_state_t state_r;
    pcw_state_t state_nxt;
    logic wide_r;
    logic done_r;
    logic win_r;
    logic sock_r;
    logic auto_r;
    wire logic start;
    wire logic tmr_running;
    wire logic tmr_expired;

    // A request while busy is ignored; the requester watches acc_busy
    assign start = (state_r == PCW_IDLE) && acc_req;

    pcw_cycle_timer #(
        .DIV(DIV),
        .LEN_W(LEN_W)
    ) u_timer (
        .mclk(mclk),
        .resetn(resetn),
        .load(start),
        .load_len(len_now),
        .running(tmr_running),
        .expired(tmr_expired)
    );

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PCW_IDLE:
                if (acc_req)
                    state_nxt = PCW_RUN;
            PCW_RUN:
                if (tmr_expired)
                    state_nxt = PCW_IDLE;
            default:
                state_nxt = PCW_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            state_r <= PCW_IDLE;
            wide_r <= 1'h0;
            done_r <= 1'h0;
            win_r <= 1'h0;
            sock_r <= 1'h0;
            auto_r <= 1'h0;
        end
        else
        begin
            state_r <= state_nxt;
            done_r <= (state_r == PCW_RUN) && tmr_expired;
            if (start)
            begin
                wide_r <= width_now;
                win_r <= acc_win;
                sock_r <= acc_sock;
                auto_r <= auto_sel;
            end
        end
    end

    assign acc_busy = (state_r == PCW_RUN);
    assign acc_wide = wide_r;
    assign acc_done = done_r;
    assign status = {3'h0, auto_r, sock_r, win_r, wide_r, acc_busy};

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [7:0] cyc_r;
    logic [7:0] snap_r;

    // Length of the running access, and the control byte it started with
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            cyc_r <= 8'h00;
            snap_r <= 8'h00;
        end
        else if (start)
        begin
            cyc_r <= 8'h01;
            snap_r <= ctrl_sel;
        end
        else if (acc_busy)
            cyc_r <= 8'(cyc_r + 8'h01);
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_start_w1;
        start && acc_win;
    endsequence

    sequence s_start_w0;
        start && !acc_win;
    endsequence

    sequence s_end_w0;
        acc_busy && tmr_expired && !win_r;
    endsequence

    AST_W1_AUTO: assert property (s_start_w1 and ctrl_sel[`PCW_B_W1_AUTO]
        |=> acc_wide == !$past(card_iois16_n))
        else $error("window 1 auto width does not follow IOIS16");

    AST_W1_IGNORE: assert property (s_start_w1 and ctrl_sel[`PCW_B_W1_AUTO]
        && ctrl_sel[`PCW_B_W1_WIDTH] && card_iois16_n |=> !acc_wide)
        else $error("window 1 width bit not ignored under auto sizing");

    AST_W1_FIXED: assert property (s_start_w1 and !ctrl_sel[`PCW_B_W1_AUTO]
        |=> acc_wide == $past(ctrl_sel[`PCW_B_W1_WIDTH]))
        else $error("window 1 fixed width wrong");

    AST_W0_WAIT: assert property (s_end_w0 and wide_r
        |-> cyc_r == 8'((`PCW_LEN_WIDE + (snap_r[`PCW_B_W0_WAIT] ? `PCW_LEN_EXTRA : 0)) * DIV))
        else $error("window 0 16-bit cycle length wrong");

    AST_W0_SHORT: assert property (s_end_w0 and !wide_r
        |-> cyc_r == 8'((snap_r[`PCW_B_W0_SHORT] ? `PCW_LEN_SHORT : `PCW_LEN_NARROW) * DIV))
        else $error("window 0 8-bit cycle length wrong");

    AST_W0_AUTO: assert property (s_start_w0 and ctrl_sel[`PCW_B_W0_AUTO]
        |=> acc_wide == !$past(card_iois16_n))
        else $error("window 0 auto width does not follow IOIS16");

    AST_W0_FIXED: assert property (s_start_w0 and !ctrl_sel[`PCW_B_W0_AUTO]
        |=> acc_wide == $past(ctrl_sel[`PCW_B_W0_WIDTH]))
        else $error("window 0 fixed width wrong");

    AST_CTRL_WRITE: assert property ((wr_a or wr_b)
        |=> (($past(wr_a) && ctrl_a_r == $past(pwdata[7:0]))
             || ($past(wr_b) && ctrl_b_r == $past(pwdata[7:0]))))
        else $error("control byte write lost");

    AST_WIDTH_HELD: assert property (acc_busy && !tmr_expired
        |=> $stable(acc_wide) && acc_busy)
        else $error("access width changed mid access");

    AST_DONE_PULSE: assert property (acc_busy && tmr_expired
        |=> acc_done && !acc_busy ##1 !acc_done)
        else $error("done pulse malformed");

endmodule

`default_nettype wire

/* pcw_card_model.sv */
// Behavioural 8-bit or 16-bit PC Card answering the width query of the socket
`timescale 1ns/1ps
`default_nettype none

module pcw_card_model (
    // Access in progress toward this card
    input wire logic access,
    // Card personality set by the bench
    input wire logic wants_wide,
    // Card pin
    output logic card_iois16_n
);
    // Pulled up while not addressed, so a stale level never sizes a cycle
    assign card_iois16_n = access ? ~wants_wide : 1'b1;
endmodule

`default_nettype wire

/* test_pccard_io_window_sizing.sv */
// Self-checking bench for the I/O window sizing and timing block
`timescale 1ns/1ps
`default_nettype none
`include "pcw_params.svh"

module test_pccard_io_window_sizing;
    localparam logic [13:0] A_ADDR = {`PCW_IDX_CTRL_A, 2'b00};
    localparam logic [13:0] B_ADDR = {`PCW_IDX_CTRL_B, 2'b00};
    localparam logic [13:0] ST_ADDR = {`PCW_IDX_STATUS, 2'b00};
    localparam logic [13:0] BAD_ADDR = 14'h2004;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic acc_req, acc_win, acc_sock, card_iois16_n, acc_busy, acc_wide, acc_done;
    logic card_wide, err;
    int errors, checks_done;

    pcw_io_sizing u_pcw_io_sizing (.mclk(mclk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .acc_req(acc_req),
        .acc_win(acc_win), .acc_sock(acc_sock), .card_iois16_n(card_iois16_n),
        .acc_busy(acc_busy), .acc_wide(acc_wide), .acc_done(acc_done));
    pcw_card_model u_pcw_card_model (.access(acc_req), .wants_wide(card_wide),
        .card_iois16_n(card_iois16_n));

    always #20 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [13:0] addr, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Length counted in edges from the taking edge to the first cycle with done
    task automatic run_acc(input string what, input logic sock, input logic win,
        input logic wide_card, input logic exp_wide, input int len);
        int n;
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_sock <= sock;
        acc_win <= win;
        card_wide <= wide_card;
        @(posedge mclk);
        acc_req <= 1'b0;
        #1;
        check({what, " width"}, {31'h0, acc_wide}, {31'h0, exp_wide});
        check({what, " busy"}, {31'h0, acc_busy}, 32'h1);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
            #1;
        end
        while (acc_done !== 1'b1 && n < 100);
        check({what, " cycles"}, n, `PCW_ISA_DIV * len);
        check({what, " idle"}, {31'h0, acc_busy}, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_defaults();
        apb(1'b0, A_ADDR, 32'h0);
        check("ctrl a reset", rd, 32'h0);
        apb(1'b0, B_ADDR, 32'h0);
        check("ctrl b reset", rd, 32'h0);
        run_acc("w0 default", 1'b0, 1'b0, 1'b1, 1'b0, 6);
        run_acc("w1 default", 1'b1, 1'b1, 1'b1, 1'b0, 6);
    endtask

    task automatic t_win0_fixed();
        apb(1'b1, A_ADDR, 32'h01);
        run_acc("w0 wide", 1'b0, 1'b0, 1'b0, 1'b1, 3);
        apb(1'b1, A_ADDR, 32'h09);
        run_acc("w0 wide wait", 1'b0, 1'b0, 1'b0, 1'b1, 4);
        apb(1'b1, A_ADDR, 32'h08);
        run_acc("w0 narrow wait", 1'b0, 1'b0, 1'b1, 1'b0, 6);
        apb(1'b1, A_ADDR, 32'h04);
        run_acc("w0 narrow short", 1'b0, 1'b0, 1'b1, 1'b0, 3);
        apb(1'b1, A_ADDR, 32'h0D);
        run_acc("w0 wide short", 1'b0, 1'b0, 1'b0, 1'b1, 4);
    endtask

    task automatic t_win0_auto();
        apb(1'b1, A_ADDR, 32'h02);
        run_acc("w0 auto wide", 1'b0, 1'b0, 1'b1, 1'b1, 3);
        run_acc("w0 auto narrow", 1'b0, 1'b0, 1'b0, 1'b0, 6);
        apb(1'b1, A_ADDR, 32'h03);
        run_acc("w0 auto over bit0", 1'b0, 1'b0, 1'b0, 1'b0, 6);
        apb(1'b1, A_ADDR, 32'h0E);
        run_acc("w0 auto wait", 1'b0, 1'b0, 1'b1, 1'b1, 4);
        run_acc("w0 auto short", 1'b0, 1'b0, 1'b0, 1'b0, 3);
    endtask

    task automatic t_win1();
        apb(1'b1, B_ADDR, 32'h10);
        run_acc("w1 wide", 1'b1, 1'b1, 1'b0, 1'b1, 3);
        apb(1'b1, B_ADDR, 32'h20);
        run_acc("w1 auto wide", 1'b1, 1'b1, 1'b1, 1'b1, 3);
        run_acc("w1 auto narrow", 1'b1, 1'b1, 1'b0, 1'b0, 6);
        apb(1'b1, B_ADDR, 32'h30);
        run_acc("w1 auto over bit4", 1'b1, 1'b1, 1'b0, 1'b0, 6);
        apb(1'b1, B_ADDR, 32'h2D);
        run_acc("w1 ignores w0 timing", 1'b1, 1'b1, 1'b1, 1'b1, 3);
        run_acc("socket a window 1", 1'b0, 1'b1, 1'b1, 1'b0, 6);
    endtask

    task automatic t_regs();
        apb(1'b0, ST_ADDR, 32'h0);
        check("status last access", rd, 32'h0000_0004);
        apb(1'b1, A_ADDR, 32'hFFFF_FFA5);
        apb(1'b0, A_ADDR, 32'h0);
        check("ctrl a readback", rd, 32'h0000_00A5);
        pstrb <= 4'hE;
        apb(1'b1, A_ADDR, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, A_ADDR, 32'h0);
        check("ctrl a lane 0 off", rd, 32'h0000_00A5);
        apb(1'b0, B_ADDR, 32'h0);
        check("ctrl b kept", rd, 32'h0000_002D);
        apb(1'b0, BAD_ADDR, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        resetn = 1'b0;
        {psel, penable, pwrite, acc_req, acc_win, acc_sock, card_wide} = 7'h00;
        paddr = 14'h0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        errors = 0;
        checks_done = 0;
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        t_defaults();
        t_win0_fixed();
        t_win0_auto();
        t_win1();
        t_regs();
        give_verdict();
    end

    initial
    begin
        #800000;
        errors++;
        give_verdict();
    end
endmodule

`default_nettype wire
